/* File: bie_exec.sv */
// execute stage for bit clear, bit set and test-skip-if-zero
`timescale 1ns/1ps
`default_nettype none
module bie_exec (
	input  wire logic                       core_clk,     // instruction clock
	input  wire logic                       srst,         // synchronous reset, high
	input  wire logic                       instrValid,   // word present this cycle
	input  wire bie_pkg::bie_instr_t        instrWord,    // instruction word
	output logic      [bie_pkg::ADDR_W-1:0] regRdAddr,    // file register read address
	input  wire logic [bie_pkg::DATA_W-1:0] regRdData,    // file register read data
	output bie_pkg::bie_wr_t                regWr,        // file register write
	output logic                            nopSlot,      // prefetched word discarded, no-op runs
	output logic                            skipTaken,    // pulse: skip decided
	output logic                            instrDone,    // pulse: bit instruction complete
	output logic                            flagWrEn      // status flag write, never raised
);
	import bie_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		bie_state_t st;                             // run or skip slot
		bie_wr_t    wr;                             // registered write request
		logic       skip;                           // skip pulse
		logic       done;                           // completion pulse
		logic       flagWr;                         // flag write strobe
		logic [DATA_W-1:0] chkRd;                   // operand seen by last word, for checks
		logic [BSEL_W-1:0] chkBit;                  // bit selected by last word, for checks
	} bie_exec_state_t;

	bie_exec_state_t   cur_ff;                      // registered state
	bie_exec_state_t   nxt_cur;                     // next state
	bie_op_t           op;                          // decoded operation
	logic              accept;                      // word taken for execution
	logic [DATA_W-1:0] aluResult;                   // modified register value
	logic              aluBitZero;                  // tested bit is zero

	// ****************************************
	// decode and read
	// ****************************************
	assign op        = bieDecode(instrWord);
	// a word arriving in the skip slot is never executed
	assign accept    = instrValid && (cur_ff.st == ST_RUN) && (op != OP_NONE);
	assign regRdAddr = instrWord.addr;

	// bit datapath
	bie_bit_alu u_alu (
		.operand (regRdData),
		.bitSel  (instrWord.bitSel),
		.op      (op),
		.result  (aluResult),
		.bitZero (aluBitZero)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		nxt_cur        = cur_ff;
		nxt_cur.wr.en  = 1'b0;
		nxt_cur.skip   = 1'b0;
		nxt_cur.done   = 1'b0;
		nxt_cur.flagWr = 1'b0;
		nxt_cur.chkRd  = regRdData;                 // operand copy for the properties
		nxt_cur.chkBit = instrWord.bitSel;          // bit copy for the properties
		case (cur_ff.st)
			ST_RUN: begin
				if (accept) begin
					case (op)
						// clear and set write back and finish in one cycle
						OP_CLR, OP_SET: begin
							nxt_cur.wr.en   = 1'b1;
							nxt_cur.wr.addr = instrWord.addr;
							nxt_cur.wr.data = aluResult;
							nxt_cur.done    = 1'b1;
						end
						// test: skip only on a zero bit
						OP_TSTZ: begin
							if (aluBitZero) begin
								nxt_cur.st   = ST_SKIP;
								nxt_cur.skip = 1'b1;
							end else begin
								nxt_cur.done = 1'b1;
							end
						end
						default: begin
							nxt_cur.done = 1'b0;
						end
					endcase
				end
			end
			// no-op slot: fetched word dropped, second cycle ends here
			ST_SKIP: begin
				nxt_cur.st   = ST_RUN;
				nxt_cur.done = 1'b1;
			end
			default: begin
				nxt_cur.st = ST_RUN;
			end
		endcase
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cur_ff <= '{st: ST_RUN, wr: '0, skip: 1'b0, done: 1'b0, flagWr: 1'b0, chkRd: '0, chkBit: '0};
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign regWr     = cur_ff.wr;
	assign nopSlot   = (cur_ff.st == ST_SKIP);
	assign skipTaken = cur_ff.skip;
	assign instrDone = cur_ff.done;
	assign flagWrEn  = cur_ff.flagWr;

	// ****************************************
	// checking helpers
	// ****************************************
	// operand copies live in the state struct, aliased here for the properties
	logic [DATA_W-1:0] chkRd_ff;                    // data read by last word
	logic [BSEL_W-1:0] chkBit_ff;                   // bit selected by last word
	assign chkRd_ff  = cur_ff.chkRd;
	assign chkBit_ff = cur_ff.chkBit;

	// ****************************************
	// assertions
	// ****************************************
	// clear writes back with only the chosen bit dropped
	property p_clear_bit;
		@(posedge core_clk) disable iff (srst)
		accept && (op == OP_CLR) |=> regWr.en && !regWr.data[chkBit_ff]
			&& ((regWr.data | (8'h01 << chkBit_ff)) == (chkRd_ff | (8'h01 << chkBit_ff)));
	endproperty
	a_clear_bit: assert property (p_clear_bit) else $error("bit clear result wrong");

	// set writes back with only the chosen bit raised
	property p_set_bit;
		@(posedge core_clk) disable iff (srst)
		accept && (op == OP_SET) |=> regWr.en && regWr.data[chkBit_ff]
			&& ((regWr.data & ~(8'h01 << chkBit_ff)) == (chkRd_ff & ~(8'h01 << chkBit_ff)));
	endproperty
	a_set_bit: assert property (p_set_bit) else $error("bit set result wrong");

	// test opens the no-op slot exactly when the bit read zero
	property p_test_skip;
		@(posedge core_clk) disable iff (srst)
		accept && (op == OP_TSTZ) |=> (nopSlot == !chkRd_ff[chkBit_ff]) && !regWr.en;
	endproperty
	a_test_skip: assert property (p_test_skip) else $error("skip decision wrong");

	// a word arriving in the slot neither writes nor skips
	property p_discard;
		@(posedge core_clk) disable iff (srst)
		nopSlot && instrValid |=> !regWr.en && !skipTaken;
	endproperty
	a_discard: assert property (p_discard) else $error("discarded word executed");

	// the slot starts in the cycle of the skip pulse and ends the test quietly
	property p_nop_slot;
		@(posedge core_clk) disable iff (srst)
		skipTaken |-> nopSlot ##1 (!nopSlot && !regWr.en && !flagWrEn && instrDone);
	endproperty
	a_nop_slot: assert property (p_nop_slot) else $error("no-op slot had effects");

	// test ends after one cycle, or after two when it skips
	property p_test_cycles;
		@(posedge core_clk) disable iff (srst)
		accept && (op == OP_TSTZ) |=> (instrDone && !nopSlot) or (!instrDone ##1 instrDone);
	endproperty
	a_test_cycles: assert property (p_test_cycles) else $error("test cycle count wrong");

	// clear and set end in one cycle without flag writes
	property p_single_cycle;
		@(posedge core_clk) disable iff (srst)
		accept && (op != OP_TSTZ) |=> instrDone && !nopSlot && !flagWrEn;
	endproperty
	a_single_cycle: assert property (p_single_cycle) else $error("clear or set not single cycle");

	// reset leaves every registered output quiet at the next edge
	property p_reset_quiet;
		@(posedge core_clk)
		srst |=> !regWr.en && !nopSlot && !skipTaken && !instrDone && !flagWrEn;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");

	// a write only ever follows an accepted clear or set
	property p_write_source;
		@(posedge core_clk) disable iff (srst)
		regWr.en |-> $past(accept) && (($past(op) == OP_CLR) || ($past(op) == OP_SET));
	endproperty
	a_write_source: assert property (p_write_source) else $error("write without clear or set");

	// the written address is the one the word named
	property p_write_addr;
		@(posedge core_clk) disable iff (srst)
		accept && (op != OP_TSTZ) |=> regWr.addr == $past(instrWord.addr);
	endproperty
	a_write_addr: assert property (p_write_addr) else $error("write address wrong");

	// the no-operation slot lasts exactly one cycle
	property p_nop_once;
		@(posedge core_clk) disable iff (srst)
		nopSlot |=> !nopSlot;
	endproperty
	a_nop_once: assert property (p_nop_once) else $error("no-op slot longer than one cycle");

	// a skip is only decided by an accepted test that read a zero bit
	property p_skip_source;
		@(posedge core_clk) disable iff (srst)
		skipTaken |-> $past(accept) && ($past(op) == OP_TSTZ) && $past(aluBitZero);
	endproperty
	a_skip_source: assert property (p_skip_source) else $error("skip without zero test");

	// completion follows an accepted word or the no-op slot
	property p_done_source;
		@(posedge core_clk) disable iff (srst)
		instrDone |-> $past(accept) || $past(nopSlot);
	endproperty
	a_done_source: assert property (p_done_source) else $error("completion without instruction");

endmodule : bie_exec
`default_nettype wire

/* File: bie_pkg.sv */
// package for the bit-oriented instruction execute block
`default_nettype none
package bie_pkg;

	// ****************************************
	// instruction field layout
	// ****************************************
	localparam int         INSTR_W    = 14;        // instruction word width
	localparam int         DATA_W     = 8;         // data memory width
	localparam int         ADDR_W     = 7;         // register address width
	localparam int         BSEL_W     = 3;         // bit selector width
	localparam logic [1:0] GRP_BIT    = 2'h1;      // bit-oriented group code
	localparam logic [1:0] SUB_CLR    = 2'h0;      // bit-clear sub code
	localparam logic [1:0] SUB_SET    = 2'h1;      // bit-set sub code
	localparam logic [1:0] SUB_TSTZ   = 2'h2;      // test, skip if zero sub code

	// ****************************************
	// cycle counts
	// ****************************************
	localparam int         CYC_SINGLE = 1;         // clear, set, untaken test
	localparam int         CYC_SKIP   = 2;         // taken test

	// ****************************************
	// carriers
	// ****************************************
	// instruction word split into its fields, msb first
	typedef struct packed {
		logic [1:0]        grp;                    // group code
		logic [1:0]        sub;                    // operation in group
		logic [BSEL_W-1:0] bitSel;                 // selected bit
		logic [ADDR_W-1:0] addr;                   // file register address
	} bie_instr_t;

	// register file write request
	typedef struct packed {
		logic              en;                     // write strobe
		logic [ADDR_W-1:0] addr;                   // write address
		logic [DATA_W-1:0] data;                   // write data
	} bie_wr_t;

	// decoded operation
	typedef enum logic [1:0] {
		OP_NONE,
		OP_CLR,
		OP_SET,
		OP_TSTZ
	} bie_op_t;

	// execute state
	typedef enum logic {
		ST_RUN,
		ST_SKIP
	} bie_state_t;

	// decode a word into its bit-oriented operation
	function automatic bie_op_t bieDecode(input bie_instr_t w);
		bie_op_t op;
		op = OP_NONE;
		if (w.grp == GRP_BIT) begin
			case (w.sub)
				SUB_CLR:  op = OP_CLR;
				SUB_SET:  op = OP_SET;
				SUB_TSTZ: op = OP_TSTZ;
				default:  op = OP_NONE;
			endcase
		end
		return op;
	endfunction : bieDecode

endpackage : bie_pkg
`default_nettype wire

/* File: bie_bit_alu.sv */
// bit manipulation datapath: clear, set and test of one bit
`timescale 1ns/1ps
`default_nettype none
module bie_bit_alu (
	input  wire logic [bie_pkg::DATA_W-1:0] operand,  // value read from file register
	input  wire logic [bie_pkg::BSEL_W-1:0] bitSel,   // bit to act on
	input  wire bie_pkg::bie_op_t           op,       // decoded operation
	output logic      [bie_pkg::DATA_W-1:0] result,   // value to write back
	output logic                            bitZero   // selected bit reads zero
);
	import bie_pkg::*;

	logic [DATA_W-1:0] mask;                        // one-hot mask of selected bit

	// ****************************************
	// one-hot mask, one term per bit
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < DATA_W; gi++) begin : g_mask
			assign mask[gi] = (bitSel == BSEL_W'(gi));
		end
	endgenerate

	// ****************************************
	// result selection
	// ****************************************
	// only the masked bit may change
	always_comb begin
		case (op)
			OP_CLR:  result = operand & ~mask;
			OP_SET:  result = operand | mask;
			default: result = operand;           // test leaves data alone
		endcase
		bitZero = ((operand & mask) == '0);
	end

endmodule : bie_bit_alu
`default_nettype wire

/* File: bie_testbench.sv */
// self-checking testbench for the bit-oriented instruction execute block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import bie_pkg::*;
	// ****************************************
	// signals
	// ****************************************
	logic              core_clk;    // instruction clock
	logic              srst;        // synchronous reset
	logic              instrValid;  // word present
	bie_instr_t        instrWord;   // word under test
	logic [ADDR_W-1:0] regRdAddr;   // read address from dut
	logic [DATA_W-1:0] regRdData;   // register content fed back
	bie_wr_t           regWr;       // write request from dut
	logic              nopSlot;     // discarded slot
	logic              skipTaken;   // skip pulse
	logic              instrDone;   // completion pulse
	logic              flagWrEn;    // status flag write
	int                miscompares; // mismatches seen
	int                num_checks;  // comparisons made
	bie_exec dut (.core_clk(core_clk), .srst(srst), .instrValid(instrValid), .instrWord(instrWord),
		.regRdAddr(regRdAddr), .regRdData(regRdData), .regWr(regWr), .nopSlot(nopSlot),
		.skipTaken(skipTaken), .instrDone(instrDone), .flagWrEn(flagWrEn));
	// ****************************************
	// helpers
	// ****************************************
	// compare one value and count it
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			$display("BAD %s expected %0h seen %0h", name, exp, seen);
			miscompares++;
		end
	endtask : check
	// wait one edge, then the fixed drive delay
	task automatic step();
		@(posedge core_clk);
		#2;
	endtask : step
	// present a word and the register content it reads
	task automatic drive(input logic vld, input logic [1:0] g, input logic [1:0] s,
		input logic [2:0] b, input logic [6:0] a, input logic [7:0] v);
		instrValid = vld;
		instrWord  = '{grp: g, sub: s, bitSel: b, addr: a};
		regRdData  = v;
	endtask : drive
	// outputs that show nothing happened
	task automatic quiet();
		check("wr_en", regWr.en, 0);
		check("done", instrDone, 0);
		check("skip", skipTaken, 0);
		check("flag", flagWrEn, 0);
	endtask : quiet
	// closing report
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	// ****************************************
	// scenarios
	// ****************************************
	// back-to-back clear and set over every bit
	task automatic clr_set();
		logic [7:0] v;
		logic [7:0] e;
		for (int s = 0; s < 2; s++) begin
			for (int b = 0; b < 8; b++) begin
				v = s ? 8'h0A : 8'hC7;
				e = s ? (v | (8'h01 << b)) : (v & ~(8'h01 << b));
				drive(1, GRP_BIT, s[1:0], b[2:0], 7'h7F - b[6:0], v);
				step();
				check("rd_addr", regRdAddr, 7'h7F - b[6:0]);
				check("wr", regWr, {1'b1, 7'h7F - b[6:0], e});
				check("done", instrDone, 1);
				check("flag", flagWrEn, 0);
			end
		end
		drive(0, 2'h0, 2'h0, 3'h0, 7'h00, 8'h00);
		step();
		check("done_end", instrDone, 0);
	endtask : clr_set
	// test with bit one: single cycle, no skip
	task automatic test_set(input int b);
		drive(1, GRP_BIT, SUB_TSTZ, b[2:0], 7'h05, 8'h01 << b);
		step();
		drive(0, 2'h0, 2'h0, 3'h0, 7'h00, 8'h00);
		check("done", instrDone, 1);
		check("skip", skipTaken, 0);
		check("nop", nopSlot, 0);
		check("wr_en", regWr.en, 0);
		step();
		check("done2", instrDone, 0);
	endtask : test_set
	// test with bit zero: next word dropped, following word runs
	task automatic test_clear(input int b);
		drive(1, GRP_BIT, SUB_TSTZ, b[2:0], 7'h11, ~(8'h01 << b));
		step();
		drive(1, GRP_BIT, SUB_SET, 3'h0, 7'h22, 8'h00);
		check("skip", skipTaken, 1);
		check("nop", nopSlot, 1);
		check("done", instrDone, 0);
		check("wr_en", regWr.en, 0);
		step();
		drive(1, GRP_BIT, SUB_CLR, 3'h7, 7'h33, 8'hFF);
		check("wr_en_drop", regWr.en, 0);
		check("done2", instrDone, 1);
		check("nop2", nopSlot, 0);
		step();
		drive(0, 2'h0, 2'h0, 3'h0, 7'h00, 8'h00);
		check("wr_next", regWr, {1'b1, 7'h33, 8'h7F});
		step();
		quiet();
	endtask : test_clear
	// reset in the skip slot clears it, and the next word then runs
	task automatic reset_mid();
		drive(1'h1, GRP_BIT, SUB_TSTZ, 3'h3, 7'h0C, 8'h00);
		step();
		check("nop_pre", nopSlot, 1'h1);
		srst = 1'h1;
		drive(1'h1, GRP_BIT, SUB_SET, 3'h1, 7'h0D, 8'h00);
		step();
		srst = 1'h0;
		drive(1'h0, 2'h0, 2'h0, 3'h0, 7'h00, 8'h00);
		quiet();
		check("nop_rst", nopSlot, 1'h0);
		step();
		quiet();
		drive(1'h1, GRP_BIT, SUB_SET, 3'h1, 7'h0D, 8'h00);
		step();
		drive(1'h0, 2'h0, 2'h0, 3'h0, 7'h00, 8'h00);
		check("wr_rst", regWr, {1'h1, 7'h0D, 8'h02});
	endtask : reset_mid
	// words outside the three forms move nothing
	task automatic ignored();
		for (int g = 0; g < 4; g++) begin
			drive(1, g[1:0], (g == 1) ? 2'h3 : 2'h0, 3'h2, 7'h44, 8'h00);
			step();
			quiet();
			check("nop_ign", nopSlot, 0);
		end
		drive(0, 2'h0, 2'h0, 3'h0, 7'h00, 8'h00);
	endtask : ignored
	// ****************************************
	// clock, watchdog and main sequence
	// ****************************************
	// free-running clock, 40 ns period
	initial begin
		core_clk = 0;
		forever #20 core_clk = ~core_clk;
	end
	// cut a hang short
	initial begin
		#200000;
		miscompares++;
		print_verdict();
	end
	// main sequence
	initial begin
		miscompares = 0;
		num_checks  = 0;
		srst        = 1;
		drive(0, 2'h0, 2'h0, 3'h0, 7'h00, 8'h00);
		repeat (16) step();
		srst = 0;
		step();
		quiet();
		clr_set();
		for (int b = 0; b < 8; b++) begin
			test_set(b);
			test_clear(b);
		end
		reset_mid();
		ignored();
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
